// File: verilog/dmr_regs_top.sv
`timescale 1ns/100ps
module dmr_regs_top (
    input  wire logic       CLK_I,
    input  wire logic       SRST_I,
    input  wire logic       MRW_I,
    input  wire logic       MRR_I,
    input  wire logic [5:0] MA_I,
    input  wire logic [7:0] OP_I,
    input  wire logic       SETPOINT_WRITE_SELECT_I,
    input  wire logic       SETPOINT_OPERATE_SELECT_I,
    input  wire logic       INIT_DONE_I,
    input  wire logic [2:0] TEMP_RATE_I,
    input  wire logic       TEMP_HOT_I,
    input  wire logic       TEMP_DERATE_I,
    input  wire logic       CLK_ABOVE_1G6_I,
    input  wire logic       WR_AP_DONE_I,
    input  wire logic       RD_AP_DONE_I,
    input  wire logic       BURST32_I,
    output logic [15:0]     DQ_O,
    output logic            DQ_VALID_O,
    output logic [5:0]      READ_LATENCY_O,
    output logic [5:0]      WRITE_LATENCY_O,
    output logic            READ_INVERSION_ENABLE_O,
    output logic            WRITE_INVERSION_ENABLE_O,
    output logic            WRITE_POSTAMBLE_LONG_O,
    output logic            PULLUP_CAL_POINT_O,
    output logic [2:0]      PULLDOWN_STRENGTH_O,
    output logic            WRITE_LEVELING_O,
    output logic            REPAIR_PROTECT_O,
    output logic            REPAIR_ENTRY_O,
    output logic            SELFREFRESH_ABORT_ENABLE_O,
    output logic            PRECHARGE_START_O
);
    import dmr_pkg::*;

    logic [7:0] rec_reg    [2];
    logic [7:0] lat_reg    [2];
    logic [7:0] ifcfg_reg  [2];
    logic       repair_protect_reg;
    logic       repair_entry_reg;
    logic       abort_reg;
    logic [1:0] offset_reg;
    logic [2:0] code_reg;
    logic [2:0] code_next;
    logic       tuf_reg;
    logic [7:0] rdata_next;
    logic [7:0] lat_op;
    logic [7:0] ifcfg_op;
    logic [5:0] nwr_op;
    logic [5:0] read_to_precharge_cycles_op;
    logic       sw;
    logic       so;
    logic       wr_thermal;
    logic       rd_thermal;

    assign sw         = SETPOINT_WRITE_SELECT_I;
    assign so         = SETPOINT_OPERATE_SELECT_I;
    assign wr_thermal = MRW_I && (MA_I == MA_THERMAL);
    assign rd_thermal = MRR_I && (MA_I == MA_THERMAL);

    // ----------------------------------------------------------------
    // Set-point copies
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rec_reg   <= '{REC_RESET, REC_RESET};
            lat_reg   <= '{LAT_RESET, LAT_RESET};
            ifcfg_reg <= '{IFCFG_RESET, IFCFG_RESET};
        end else if (MRW_I) begin
            case (MA_I)
                MA_RECOVERY: rec_reg[sw]   <= OP_I;
                MA_LATENCY:  lat_reg[sw]   <= OP_I;
                MA_IFCFG:    ifcfg_reg[sw] <= OP_I;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Repair protection and thermal writes
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            repair_protect_reg <= 1'b0;
        end else if (MRW_I && (MA_I == MA_IFCFG) && OP_I[IF_PROT_BIT]) begin
            repair_protect_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            repair_entry_reg <= 1'b0;
            abort_reg        <= 1'b0;
            offset_reg       <= 2'h0;
        end else if (wr_thermal) begin
            abort_reg  <= OP_I[TH_ABORT_BIT];
            offset_reg <= OP_I[TH_OFFS_LSB +: 2];
            if (!(OP_I[TH_ENTRY_BIT] && repair_protect_reg)) begin
                repair_entry_reg <= OP_I[TH_ENTRY_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Refresh rate code and update flag
    // ----------------------------------------------------------------
    always_comb begin
        code_next = code_reg;
        if (INIT_DONE_I) begin
            if (TEMP_DERATE_I) begin
                code_next = TH_CODE_DERATE;
            end else begin
                code_next = {TEMP_HOT_I, TEMP_RATE_I[1:0]};
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            code_reg <= TH_CODE_DEFAULT;
        end else begin
            code_reg <= code_next;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            tuf_reg <= 1'b0;
        end else if (code_next != code_reg) begin
            tuf_reg <= 1'b1;
        end else if (rd_thermal) begin
            tuf_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Mode register read
    // ----------------------------------------------------------------
    always_comb begin
        case (MA_I)
            MA_RECOVERY: rdata_next = rec_reg[sw];
            MA_LATENCY:  rdata_next = lat_reg[sw];
            MA_IFCFG: begin
                rdata_next              = ifcfg_reg[sw];
                rdata_next[IF_PROT_BIT] = repair_protect_reg;
            end
            MA_THERMAL:  rdata_next = {tuf_reg, offset_reg, repair_entry_reg,
                                       abort_reg, code_reg};
            MA_DEVID:    rdata_next = {DEVID_WIDTH, DEVID_DENSITY,
                                       DEVID_TYPE};
            default:     rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            DQ_O       <= 16'h0000;
            DQ_VALID_O <= 1'b0;
        end else begin
            DQ_VALID_O <= MRR_I;
            if (MRR_I) begin
                DQ_O <= {8'h00, rdata_next};
            end
        end
    end

    // ----------------------------------------------------------------
    // Operating copy decode
    // ----------------------------------------------------------------
    assign lat_op   = lat_reg[so];
    assign ifcfg_op = ifcfg_reg[so];
    assign nwr_op   = dmr_nwr_cycles(rec_reg[so][REC_NWR_LSB +: 3]);
    assign read_to_precharge_cycles_op  = dmr_read_to_precharge_cycles_cycles(lat_op[LAT_RL_LSB +: 3]);

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            READ_LATENCY_O           <= 6'h00;
            WRITE_LATENCY_O          <= 6'h00;
            READ_INVERSION_ENABLE_O  <= 1'b0;
            WRITE_INVERSION_ENABLE_O <= 1'b0;
            WRITE_POSTAMBLE_LONG_O   <= 1'b0;
            PULLUP_CAL_POINT_O       <= 1'b0;
            PULLDOWN_STRENGTH_O      <= 3'h0;
            WRITE_LEVELING_O         <= 1'b0;
        end else begin
            READ_LATENCY_O <= dmr_rl_cycles(lat_op[LAT_RL_LSB +: 3],
                                            ifcfg_op[IF_RDINV_BIT]);
            WRITE_LATENCY_O <= dmr_wl_cycles(lat_op[LAT_WL_LSB +: 3],
                                             lat_op[LAT_WLS_BIT]);
            READ_INVERSION_ENABLE_O  <= ifcfg_op[IF_RDINV_BIT];
            WRITE_INVERSION_ENABLE_O <= ifcfg_op[IF_WRINV_BIT];
            WRITE_POSTAMBLE_LONG_O   <= ifcfg_op[IF_PST_BIT] && CLK_ABOVE_1G6_I;
            PULLUP_CAL_POINT_O       <= ifcfg_op[IF_PUCAL_BIT];
            PULLDOWN_STRENGTH_O      <= ifcfg_op[IF_PULLDOWN_STRENGTH_LSB +: 3];
            WRITE_LEVELING_O         <= lat_op[LAT_WRLEV_BIT];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            REPAIR_PROTECT_O           <= 1'b0;
            REPAIR_ENTRY_O             <= 1'b0;
            SELFREFRESH_ABORT_ENABLE_O <= 1'b0;
        end else begin
            REPAIR_PROTECT_O           <= repair_protect_reg;
            REPAIR_ENTRY_O             <= repair_entry_reg;
            SELFREFRESH_ABORT_ENABLE_O <= abort_reg;
        end
    end

    // ----------------------------------------------------------------
    // Auto-precharge timing
    // ----------------------------------------------------------------
    dmr_ap_timer u_ap_timer (
        .clk_i     (CLK_I),
        .srst_i    (SRST_I),
        .wr_done_i (WR_AP_DONE_I),
        .rd_done_i (RD_AP_DONE_I),
        .burst32_i (BURST32_I),
        .nwr_i     (nwr_op),
        .read_to_precharge_cycles_i    (read_to_precharge_cycles_op),
        .start_o   (PRECHARGE_START_O)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_protect_sticky: assert property (@(posedge CLK_I) disable iff (SRST_I)
        $past(repair_protect_reg) |-> repair_protect_reg)
        else $error("repair protection dropped");
    chk_entry_blocked: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (wr_thermal && OP_I[TH_ENTRY_BIT] && repair_protect_reg && !repair_entry_reg)
        |=> ##1 !REPAIR_ENTRY_O)
        else $error("repair entry accepted while protected");
    chk_entry_write: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (wr_thermal && !repair_protect_reg) |=> ##1 REPAIR_ENTRY_O == $past(OP_I[TH_ENTRY_BIT], 2))
        else $error("repair entry not following write");
    chk_thermal_mask: assert property (@(posedge CLK_I) disable iff (SRST_I)
        wr_thermal |=> code_reg == $past(code_next) && abort_reg == $past(OP_I[TH_ABORT_BIT])
        && offset_reg == $past(OP_I[TH_OFFS_LSB +: 2]))
        else $error("thermal write bits wrong");
    chk_entry_exit: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (wr_thermal && !OP_I[TH_ENTRY_BIT]) |=> !repair_entry_reg)
        else $error("repair entry not left on write of 0");
    chk_code_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
        !INIT_DONE_I |=> code_reg == $past(code_reg))
        else $error("refresh code moved before initialization");
    chk_read_strobe: assert property (@(posedge CLK_I) disable iff (SRST_I)
        MRR_I |=> DQ_VALID_O && DQ_O[15:8] == 8'h00)
        else $error("read answer missing or upper lines driven");
    chk_valid_pulse: assert property (@(posedge CLK_I) disable iff (SRST_I)
        DQ_VALID_O |-> $past(MRR_I))
        else $error("read valid without read command");
    chk_tuf_clear: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (rd_thermal && code_next == code_reg) |=> !tuf_reg)
        else $error("update flag not cleared by read");
    chk_tuf_set: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (code_next != code_reg) |=> tuf_reg && code_reg != $past(code_reg))
        else $error("update flag missed code change");
    chk_derate_code: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (INIT_DONE_I && TEMP_DERATE_I) |=> code_reg == 3'h6)
        else $error("derating code not reported");
    chk_hot_topbit: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (INIT_DONE_I && TEMP_HOT_I) |=> code_reg[2])
        else $error("hot code without top bit");
    chk_devid_read: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (MRR_I && MA_I == MA_DEVID) |=> DQ_VALID_O && DQ_O == 16'h0010)
        else $error("identification read wrong");
    chk_postamble: assert property (@(posedge CLK_I) disable iff (SRST_I)
        WRITE_POSTAMBLE_LONG_O |-> $past(CLK_ABOVE_1G6_I))
        else $error("long postamble at low clock");
    chk_inactive_copy: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (MRW_I && MA_I == MA_LATENCY && sw != so) ##1 $stable(so) ##1 $stable(so)
        |-> $stable(WRITE_LATENCY_O))
        else $error("inactive copy changed behaviour");
    cov_tuf_read: cover property (@(posedge CLK_I) disable iff (SRST_I)
        tuf_reg ##1 rd_thermal ##1 !tuf_reg);
    cov_protect_block: cover property (@(posedge CLK_I) disable iff (SRST_I)
        wr_thermal && OP_I[TH_ENTRY_BIT] && repair_protect_reg);
    cov_setb_latency: cover property (@(posedge CLK_I) disable iff (SRST_I)
        MRW_I && MA_I == MA_LATENCY && OP_I[LAT_WLS_BIT]);
endmodule : dmr_regs_top

// File: inc/dmr_pkg.sv
package dmr_pkg;
    // ----------------------------------------------------------------
    // Mode register addresses
    // ----------------------------------------------------------------
    localparam logic [5:0] MA_RECOVERY = 6'h01;
    localparam logic [5:0] MA_LATENCY  = 6'h02;
    localparam logic [5:0] MA_IFCFG    = 6'h03;
    localparam logic [5:0] MA_THERMAL  = 6'h04;
    localparam logic [5:0] MA_DEVID    = 6'h08;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int REC_NWR_LSB   = 4;
    localparam int LAT_RL_LSB    = 0;
    localparam int LAT_WL_LSB    = 3;
    localparam int LAT_WLS_BIT   = 6;
    localparam int LAT_WRLEV_BIT = 7;
    localparam int IF_PUCAL_BIT  = 0;
    localparam int IF_PST_BIT    = 1;
    localparam int IF_PROT_BIT   = 2;
    localparam int IF_PULLDOWN_STRENGTH_LSB   = 3;
    localparam int IF_RDINV_BIT  = 6;
    localparam int IF_WRINV_BIT  = 7;
    localparam int TH_ABORT_BIT  = 3;
    localparam int TH_ENTRY_BIT  = 4;
    localparam int TH_OFFS_LSB   = 5;

    // ----------------------------------------------------------------
    // Reset values and fixed codes
    // ----------------------------------------------------------------
    localparam logic [7:0] REC_RESET       = 8'h00;
    localparam logic [7:0] LAT_RESET       = 8'h00;
    localparam logic [7:0] IFCFG_RESET     = 8'h30;
    localparam logic [2:0] TH_CODE_DEFAULT = 3'h3;
    localparam logic [2:0] TH_CODE_DERATE  = 3'h6;
    localparam logic [1:0] DEVID_TYPE      = 2'h0;
    localparam logic [3:0] DEVID_DENSITY   = 4'h4;
    localparam logic [1:0] DEVID_WIDTH     = 2'h0;
    localparam logic [5:0] BL32_EXTRA      = 6'h08;

    // ----------------------------------------------------------------
    // Latency tables, cycles
    // ----------------------------------------------------------------
    function automatic logic [5:0] dmr_rl_cycles(input logic [2:0] c, input logic inv);
        logic [5:0] plain [8];
        logic [5:0] dbi   [8];
        plain = '{6'd6, 6'd10, 6'd14, 6'd20, 6'd24, 6'd28, 6'd32, 6'd36};
        dbi   = '{6'd6, 6'd12, 6'd16, 6'd22, 6'd28, 6'd32, 6'd36, 6'd40};
        return inv ? dbi[c] : plain[c];
    endfunction : dmr_rl_cycles

    function automatic logic [5:0] dmr_wl_cycles(input logic [2:0] c, input logic set_b);
        logic [5:0] set_a [8];
        logic [5:0] set_bt[8];
        set_a  = '{6'd4, 6'd6, 6'd8, 6'd10, 6'd12, 6'd14, 6'd16, 6'd18};
        set_bt = '{6'd4, 6'd8, 6'd12, 6'd18, 6'd22, 6'd26, 6'd30, 6'd34};
        return set_b ? set_bt[c] : set_a[c];
    endfunction : dmr_wl_cycles

    function automatic logic [5:0] dmr_nwr_cycles(input logic [2:0] c);
        logic [5:0] t [8];
        t = '{6'd6, 6'd10, 6'd16, 6'd20, 6'd24, 6'd30, 6'd34, 6'd40};
        return t[c];
    endfunction : dmr_nwr_cycles

    function automatic logic [5:0] dmr_read_to_precharge_cycles_cycles(input logic [2:0] c);
        logic [5:0] t [8];
        t = '{6'd8, 6'd8, 6'd8, 6'd8, 6'd10, 6'd12, 6'd14, 6'd16};
        return t[c];
    endfunction : dmr_read_to_precharge_cycles_cycles
endpackage : dmr_pkg

// File: verilog/dmr_ap_timer.sv
`timescale 1ns/100ps
module dmr_ap_timer (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       wr_done_i,
    input  wire logic       rd_done_i,
    input  wire logic       burst32_i,
    input  wire logic [5:0] nwr_i,
    input  wire logic [5:0] read_to_precharge_cycles_i,
    output logic            start_o
);
    import dmr_pkg::*;

    typedef enum logic [0:0] {
        AP_IDLE  = 1'b0,
        AP_COUNT = 1'b1
    } dmr_ap_state_t;

    dmr_ap_state_t state_reg;
    logic [5:0]    cnt_reg;
    logic [5:0]    load_next;

    // ----------------------------------------------------------------
    // Delay selection
    // ----------------------------------------------------------------
    always_comb begin
        load_next = nwr_i;
        if (!wr_done_i) begin
            load_next = burst32_i ? 6'(read_to_precharge_cycles_i + BL32_EXTRA) : read_to_precharge_cycles_i;
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= AP_IDLE;
            cnt_reg   <= 6'h00;
            start_o   <= 1'b0;
        end else begin
            start_o <= (state_reg == AP_COUNT) && (cnt_reg == 6'h01);
            if (wr_done_i || rd_done_i) begin
                state_reg <= AP_COUNT;
                cnt_reg   <= load_next;
            end else begin
                case (state_reg)
                    AP_COUNT: begin
                        cnt_reg <= 6'(cnt_reg - 6'h01);
                        if (cnt_reg == 6'h01) begin
                            state_reg <= AP_IDLE;
                        end
                    end
                    default: state_reg <= AP_IDLE;
                endcase
            end
        end
    end

    chk_ap_fire_time: assert property (@(posedge clk_i) disable iff (srst_i)
        start_o |-> $past(state_reg) == AP_COUNT && $past(cnt_reg) == 6'h01)
        else $error("precharge start without expired count");
    chk_ap_read_load: assert property (@(posedge clk_i) disable iff (srst_i)
        (rd_done_i && !wr_done_i)
        |=> cnt_reg == $past(burst32_i ? 6'(read_to_precharge_cycles_i + BL32_EXTRA) : read_to_precharge_cycles_i))
        else $error("read precharge delay loaded wrong");
    chk_ap_write_load: assert property (@(posedge clk_i) disable iff (srst_i)
        wr_done_i |=> cnt_reg == $past(nwr_i))
        else $error("write recovery delay loaded wrong");
    cov_ap_bl32: cover property (@(posedge clk_i) disable iff (srst_i)
        rd_done_i && burst32_i ##[1:30] start_o);
endmodule : dmr_ap_timer

// File: test/dmr_ctrl_model.sv
`timescale 1ns/100ps
module dmr_ctrl_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        dqv_i,
    output logic             mrw_o,
    output logic             mrr_o,
    output logic [5:0]       ma_o,
    output logic [7:0]       op_o
);
    logic [15:0] rd_q;
    logic        rd_v;
    initial begin
        mrw_o = 1'b0;
        mrr_o = 1'b0;
        ma_o  = 6'h3f;
        op_o  = 8'h00;
    end
    // ----------------------------------------------------------------
    // One command, one cycle; single channel at a fixed 25 MHz
    // ----------------------------------------------------------------
    task automatic cmd(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_i);
        mrw_o = w;
        mrr_o = !w;
        ma_o  = a;
        op_o  = d;
        @(negedge clk_i);
        rd_q  = dq_i;
        rd_v  = dqv_i;
        mrw_o = 1'b0;
        mrr_o = 1'b0;
        ma_o  = ~a;
        op_o  = ~d;
    endtask : cmd
endmodule : dmr_ctrl_model

// File: test/dmr_regs_top_bench.sv
`timescale 1ns/100ps
module dmr_regs_top_bench;
    logic        clk, srst, swsel, sosel, init, hot, der, fast, wap, rap, b32;
    logic [2:0]  rate, pulldown_strength;
    logic [5:0]  ma, rl, wl;
    logic [7:0]  op;
    logic [15:0] dq;
    logic        mrw, mrr, dqv, rinv, winv, pst, pucal, wlev, prot, ent, abt, pc;
    int rlp[8] = '{6, 10, 14, 20, 24, 28, 32, 36};
    int rld[8] = '{6, 12, 16, 22, 28, 32, 36, 40};
    int wla[8] = '{4, 6, 8, 10, 12, 14, 16, 18};
    int wlb[8] = '{4, 8, 12, 18, 22, 26, 30, 34};
    int write_recovery_cycles[8] = '{6, 10, 16, 20, 24, 30, 34, 40};
    int rtp[8] = '{8, 8, 8, 8, 10, 12, 14, 16};
    int n_mismatch, n_checks, seed, c, k, m_th, m_prot, m_flag, m_code;
    int m_lat[2], m_ifc[2];
    dmr_regs_top uut (.CLK_I(clk), .SRST_I(srst), .MRW_I(mrw), .MRR_I(mrr), .MA_I(ma),
        .OP_I(op), .SETPOINT_WRITE_SELECT_I(swsel), .SETPOINT_OPERATE_SELECT_I(sosel),
        .INIT_DONE_I(init), .TEMP_RATE_I(rate), .TEMP_HOT_I(hot), .TEMP_DERATE_I(der),
        .CLK_ABOVE_1G6_I(fast), .WR_AP_DONE_I(wap), .RD_AP_DONE_I(rap), .BURST32_I(b32),
        .DQ_O(dq), .DQ_VALID_O(dqv), .READ_LATENCY_O(rl), .WRITE_LATENCY_O(wl),
        .READ_INVERSION_ENABLE_O(rinv), .WRITE_INVERSION_ENABLE_O(winv),
        .WRITE_POSTAMBLE_LONG_O(pst), .PULLUP_CAL_POINT_O(pucal),
        .PULLDOWN_STRENGTH_O(pulldown_strength), .WRITE_LEVELING_O(wlev), .REPAIR_PROTECT_O(prot),
        .REPAIR_ENTRY_O(ent), .SELFREFRESH_ABORT_ENABLE_O(abt), .PRECHARGE_START_O(pc));
    dmr_ctrl_model ctl (.clk_i(clk), .dq_i(dq), .dqv_i(dqv), .mrw_o(mrw), .mrr_o(mrr),
        .ma_o(ma), .op_o(op));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Reference model and compares
    // ----------------------------------------------------------------
    task automatic mdl_reset;
        m_lat = '{0, 0};
        m_ifc = '{8'h30, 8'h30};
        m_th = 0;
        m_prot = 0;
        m_flag = 0;
        m_code = 3;
    endtask : mdl_reset
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    function automatic logic [15:0] exp_rd(input logic [5:0] a);
        case (a)
            6'h02: return 16'(m_lat[swsel]);
            6'h03: return 16'((m_ifc[swsel] & 8'hfb) | (m_prot << 2));
            6'h04: return 16'(m_th | (m_flag << 7) | m_code);
            6'h08: return 16'h0010;
            default: return 16'h0000;
        endcase
    endfunction : exp_rd
    task automatic cmp_rd(input logic [5:0] a);
        ctl.cmd(1'b0, a, 8'(seed));
        cmp({ctl.rd_v, ctl.rd_q}, {1'b1, exp_rd(a)});
        @(negedge clk);
        cmp({dqv, dq}, {1'b0, exp_rd(a)});
        if (a == 6'h04)
            m_flag = 0;
    endtask : cmp_rd
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        ctl.cmd(1'b1, a, d);
        if (a == 6'h02)
            m_lat[swsel] = d;
        if (a == 6'h03)
            m_ifc[swsel] = d;
        if (a == 6'h03 && d[2])
            m_prot = 1;
        if (a == 6'h04)
            m_th = (m_prot != 0 && d[4]) ? (d & 8'h68) | (m_th & 8'h10) : d & 8'h78;
        repeat (2) @(negedge clk);
    endtask : wr
    task automatic chk_pins;
        int i;
        int l;
        i = m_ifc[sosel];
        l = m_lat[sosel];
        cmp(17'(rl), 17'(i[6] ? rld[l % 8] : rlp[l % 8]));
        cmp(17'(wl), 17'(l[6] ? wlb[(l / 8) % 8] : wla[(l / 8) % 8]));
        cmp({winv, rinv, pulldown_strength, pst, pucal}, {i[7:3], i[1] & fast, i[0]});
        cmp({wlev, prot, ent, abt}, {l[7], m_prot[0], m_th[4], m_th[3]});
    endtask : chk_pins
    task automatic ap(input logic w, input logic l, input int n);
        @(negedge clk);
        wap = w;
        rap = !w;
        b32 = l;
        @(negedge clk);
        wap = 1'b0;
        rap = 1'b0;
        k = 0;
        while (pc !== 1'b1 && k < 60) begin
            @(negedge clk);
            k++;
        end
        cmp(17'(k), 17'(n));
        if (k == 60)
            end_sim();
        @(negedge clk);
        cmp(17'(pc), 17'h0_0000);
    endtask : ap
    task automatic temp(input logic [2:0] r, input logic h, input logic d);
        rate = r;
        hot = h;
        der = d;
        repeat (3) @(negedge clk);
        k = d ? 6 : {h, r[1:0]};
        if (k != m_code)
            m_flag = 1;
        m_code = k;
        cmp_rd(6'h04);
        cmp_rd(6'h04);
    endtask : temp
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h6edd_b4ff;
        {srst, swsel, sosel, init, hot, der, fast, wap, rap, b32} = 10'h200;
        rate = 3'h3;
        mdl_reset();
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (2) @(negedge clk);
        chk_pins();
        cmp_rd(6'h04);
        wr(6'h08, 8'hff);
        cmp_rd(6'h08);
        cmp_rd(6'h05);
        for (c = 0; c < 16; c++) begin
            k = $random(seed);
            fast = c[1];
            wr(6'h02, {k[7], c[3], k[5:3], c[2:0]});
            wr(6'h03, {k[15], c[0] ^ c[3], k[13:11], 1'b0, k[9:8]});
            wr(6'h01, {1'b0, c[2:0], 4'h0});
            chk_pins();
            cmp_rd(6'h02);
            cmp_rd(6'h03);
            ap(1'b1, 1'b0, write_recovery_cycles[c % 8]);
            ap(1'b0, c[3], rtp[c % 8] + 8 * c[3]);
        end
        swsel = 1'b1;
        wr(6'h02, 8'h3f);
        chk_pins();
        cmp_rd(6'h02);
        swsel = 1'b0;
        cmp_rd(6'h02);
        sosel = 1'b1;
        repeat (2) @(negedge clk);
        chk_pins();
        sosel = 1'b0;
        wr(6'h04, 8'h18);
        chk_pins();
        wr(6'h04, 8'h00);
        wr(6'h03, 8'h34);
        wr(6'h03, 8'h30);
        wr(6'h04, 8'hff);
        chk_pins();
        cmp_rd(6'h03);
        init = 1'b1;
        // Sensor never asks for the unsafe codes
        for (c = 1; c < 4; c++)
            temp(3'(c), 1'b0, 1'b0);
        temp(3'h1, 1'b1, 1'b0);
        temp(3'h1, 1'b1, 1'b1);
        temp(3'h3, 1'b0, 1'b0);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        mdl_reset();
        repeat (2) @(negedge clk);
        chk_pins();
        cmp_rd(6'h03);
        end_sim();
    end
endmodule : dmr_regs_top_bench
